// *** ctu_regs.vh ***
// Register offsets, field positions, codes and reset values of the timer unit
`ifndef CTU_REGS_VH
`define CTU_REGS_VH

`define CTU_OFF_CTRL 8'h00
`define CTU_OFF_PSC 8'h04
`define CTU_OFF_ARR 8'h08
`define CTU_OFF_CNT 8'h0c
`define CTU_OFF_CCMR 8'h10
`define CTU_OFF_CCR0 8'h14
`define CTU_OFF_CCR1 8'h18
`define CTU_OFF_CCR2 8'h1c
`define CTU_OFF_CCR3 8'h20
`define CTU_OFF_DTR 8'h24
`define CTU_OFF_SMCR 8'h28
`define CTU_OFF_STAT 8'h2c
`define CTU_OFF_IER 8'h30
`define CTU_OFF_DMAEN 8'h34

`define CTU_CTRL_EN 0
`define CTU_CTRL_DIR 1
`define CTU_CTRL_CMS_LO 2
`define CTU_CTRL_CMS_HI 3
`define CTU_CTRL_OPM 4
`define CTU_CTRL_FRZ 5
`define CTU_CTRL_KDS 6
`define CTU_CTRL_DIRSTAT 7

`define CTU_DTR_DT_HI 7
`define CTU_DTR_CPE 8
`define CTU_DTR_MOE 9

`define CTU_CH_OFF 3'h0
`define CTU_CH_CAP 3'h1
`define CTU_CH_TOGGLE 3'h2
`define CTU_CH_PWM1 3'h3
`define CTU_CH_PWM2 3'h4

`define CTU_SM_OFF 3'h0
`define CTU_SM_START 3'h1
`define CTU_SM_GATE 3'h2
`define CTU_SM_EXTCLK 3'h3
`define CTU_SM_ENC 3'h4
`define CTU_SM_HALL 3'h5

`define CTU_ST_UPD 0
`define CTU_ST_CC0 1
`define CTU_ST_TRG 5
`define CTU_ST_W 6

`define CTU_VAR_ADV 2'h0
`define CTU_VAR_FULL 2'h1
`define CTU_VAR_REDUCED 2'h2
`define CTU_VAR_BASIC 2'h3

`define CTU_RST_CTRL 8'h00
`define CTU_RST_PSC 16'h0000
`define CTU_RST_ARR 32'h0000ffff
`define CTU_RST_DTR 10'h000
`define CTU_MASK16 32'h0000ffff
`define CTU_MASK32 32'hffffffff

`endif

// *** ctu_deadtime.v ***
// Dead-time insertion for one complementary output pair
`timescale 1ns/100ps
`default_nettype none
module ctu_deadtime (
    input wire clk_in,
    input wire resetn_in,
    input wire ref_in,
    input wire comp_en_in,
    input wire [7:0] dead_in,
    output reg p_out,
    output reg n_out
);
    reg ref_d_ff;
    reg [7:0] wait_ff;

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ref_d_ff <= 1'b0;
            wait_ff <= 8'h00;
            p_out <= 1'b0;
            n_out <= 1'b0;
        end else if (!comp_en_in) begin
            ref_d_ff <= ref_in;
            wait_ff <= 8'h00;
            p_out <= ref_in;
            n_out <= 1'b0;
        end else if (ref_in != ref_d_ff) begin
            // Both sides off while the dead time runs
            ref_d_ff <= ref_in;
            wait_ff <= (dead_in == 8'h00) ? 8'h00 : dead_in - 8'h01;
            p_out <= (dead_in == 8'h00) ? ref_in : 1'b0;
            n_out <= (dead_in == 8'h00) ? ~ref_in : 1'b0;
        end else if (wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
        end else begin
            p_out <= ref_d_ff;
            n_out <= ~ref_d_ff;
        end
    end
endmodule // ctu_deadtime
`default_nettype wire

// *** ctu_timer.v ***
// Configurable timer unit: prescaler, auto-reload counter, channels, link
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "ctu_regs.vh"

// Notes on behaviour
// - Counter is 16 or 32 bits, reloads from auto-reload, after 16-bit prescaler.
// - Prescaler divides kernel clock by any integer from 1 to 65536.
// - Advanced and full variants count up, down, up/down; others up only.
// - Advanced and full variants have four channels: capture, compare, PWM, one-pulse.
// - Reduced variants have one or two channels; basic variant has none.
// - PWM may be edge-aligned or center-aligned by configuration.
// - Advanced variant drives three complementary pairs with programmable dead time.
// - Advanced PWM reaches every duty cycle from zero to one hundred percent.
// - Timers exchange triggers to start, gate or clock one another.
// - Advanced, full and basic variants raise DMA requests; reduced ones never.
// - Full variant decodes quadrature encoders and three hall sensors.
// - Counter can freeze while the processor is halted in debug.
// - Basic variant is a 16-bit time base that triggers the DAC.
// - Kernel clock maximum of 90 or 180 MHz follows a select bit.
module ctu_timer #(
    parameter [1:0] VARIANT = `CTU_VAR_ADV,
    parameter WIDE = 0,
    parameter [2:0] REDUCED_CH = 3'h2
) (
    input wire clk_in,
    input wire resetn_in,
    input wire [7:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [3:0] ch_in,
    input wire trig_in,
    input wire dbg_halt_in,
    output reg [31:0] rdata_out,
    output wire [3:0] ch_out,
    output wire [3:0] chn_out,
    output reg trgo_out,
    output reg dac_trig_out,
    output reg irq_out,
    output reg dma_req_out,
    output reg kernel_clock_double_select_out
);
    function [2:0] ch_count;
        input [1:0] v;
        begin
            case (v)
                `CTU_VAR_ADV: ch_count = 3'h4;
                `CTU_VAR_FULL: ch_count = 3'h4;
                `CTU_VAR_REDUCED: ch_count = REDUCED_CH;
                default: ch_count = 3'h0;
            endcase
        end
    endfunction

    localparam [2:0] NCH = ch_count(VARIANT);
    localparam [31:0] CMASK = (WIDE != 0) ? `CTU_MASK32 : `CTU_MASK16;
    localparam UPDOWN_OK = (VARIANT == `CTU_VAR_ADV) || (VARIANT == `CTU_VAR_FULL);
    localparam HAS_DMA = (VARIANT != `CTU_VAR_REDUCED);
    localparam IS_ADV = (VARIANT == `CTU_VAR_ADV);
    localparam IS_FULL = (VARIANT == `CTU_VAR_FULL);

    reg [7:0] ctrl_ff;
    reg [15:0] psc_ff;
    reg [15:0] psc_cnt_ff;
    reg [31:0] arr_ff;
    reg [31:0] cnt_ff;
    reg dir_ff;
    reg [15:0] ccmr_ff;
    reg [31:0] ccr_ff [0:3];
    reg [9:0] dtr_ff;
    reg [2:0] smcr_ff;
    reg [`CTU_ST_W-1:0] stat_ff;
    reg [`CTU_ST_W-1:0] ier_ff;
    reg [`CTU_ST_W-1:0] dmaen_ff;
    reg [3:0] chin_d_ff;
    reg trig_d_ff;
    reg [3:0] ref_ff;

    reg [31:0] nxt_cnt;
    reg nxt_dir;
    reg upd;
    reg up;
    reg [3:0] cc_evt;
    reg [3:0] nxt_ref;
    reg [31:0] rd_val;
    reg [`CTU_ST_W-1:0] nxt_stat;
    reg [7:0] nxt_ctrl;
    integer i;
    integer j;

    wire wr_ctrl = wr_in && (addr_in == `CTU_OFF_CTRL);
    wire wr_cnt = wr_in && (addr_in == `CTU_OFF_CNT);
    wire wr_stat = wr_in && (addr_in == `CTU_OFF_STAT);
    wire [1:0] cms_eff = UPDOWN_OK ? ctrl_ff[`CTU_CTRL_CMS_HI:`CTU_CTRL_CMS_LO] : 2'h0;
    wire dir_eff = UPDOWN_OK ? ctrl_ff[`CTU_CTRL_DIR] : 1'b0;
    wire frozen = ctrl_ff[`CTU_CTRL_FRZ] & dbg_halt_in;
    wire trig_rise = trig_in & ~trig_d_ff;
    wire enc_mode = IS_FULL && (smcr_ff == `CTU_SM_ENC);
    wire hall_mode = IS_FULL && (smcr_ff == `CTU_SM_HALL);
    wire enc_edge = (ch_in[0] != chin_d_ff[0]) || (ch_in[1] != chin_d_ff[1]);
    wire enc_up = ch_in[0] ^ chin_d_ff[1];
    wire hall_chg = hall_mode && ((^ch_in[2:0]) != (^chin_d_ff[2:0]));
    wire gate_ok = (smcr_ff != `CTU_SM_GATE) || trig_in;
    wire psc_run = ctrl_ff[`CTU_CTRL_EN] && !frozen && gate_ok;
    wire psc_tick = psc_run && (psc_cnt_ff == psc_ff);
    wire ext_tick = (smcr_ff == `CTU_SM_EXTCLK) && trig_rise && ctrl_ff[`CTU_CTRL_EN] && !frozen;
    wire cnt_tick = enc_mode ? (enc_edge && !frozen && ctrl_ff[`CTU_CTRL_EN]) :
                    (smcr_ff == `CTU_SM_EXTCLK) ? ext_tick : psc_tick;

    // Prescaler: counts 0..psc, giving a division by psc+1
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            psc_cnt_ff <= 16'h0000;
        end else if (!psc_run || psc_tick) begin
            psc_cnt_ff <= 16'h0000;
        end else begin
            psc_cnt_ff <= psc_cnt_ff + 16'h0001;
        end
    end

    // Counter step and update event
    always @* begin
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        upd = 1'b0;
        up = 1'b1;
        if (wr_cnt) begin
            nxt_cnt = wdata_in & CMASK;
        end else if (hall_chg) begin
            nxt_cnt = 32'h0;
        end else if (cnt_tick) begin
            if (cms_eff == 2'h0 || enc_mode) begin
                up = enc_mode ? enc_up : ~dir_eff;
                nxt_dir = ~up;
                if (up) begin
                    if (cnt_ff >= arr_ff) begin
                        nxt_cnt = 32'h0;
                        upd = ~enc_mode | (cnt_ff == arr_ff);
                    end else begin
                        nxt_cnt = (cnt_ff + 32'h1) & CMASK;
                    end
                end else begin
                    if (cnt_ff == 32'h0) begin
                        nxt_cnt = arr_ff;
                        upd = 1'b1;
                    end else begin
                        nxt_cnt = cnt_ff - 32'h1;
                    end
                end
            end else if (!dir_ff) begin
                // Center-aligned: turn at the auto-reload value and at zero
                if (cnt_ff >= arr_ff) begin
                    nxt_dir = 1'b1;
                    nxt_cnt = (arr_ff == 32'h0) ? 32'h0 : arr_ff - 32'h1;
                    upd = 1'b1;
                end else begin
                    nxt_cnt = (cnt_ff + 32'h1) & CMASK;
                end
            end else begin
                if (cnt_ff == 32'h0) begin
                    nxt_dir = 1'b0;
                    nxt_cnt = (arr_ff == 32'h0) ? 32'h0 : 32'h1;
                    upd = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - 32'h1;
                end
            end
        end
    end

    // Channel reference levels and capture/compare events
    always @* begin
        nxt_ref = ref_ff;
        cc_evt = 4'h0;
        for (i = 0; i < 4; i = i + 1) begin
            if (i < NCH) begin
                case (ccmr_ff[4*i +: 3])
                    `CTU_CH_CAP: begin
                        nxt_ref[i] = 1'b0;
                        cc_evt[i] = (ch_in[i] & ~chin_d_ff[i]) | ((i == 0) && hall_chg);
                    end
                    `CTU_CH_TOGGLE: begin
                        cc_evt[i] = cnt_tick && (cnt_ff == ccr_ff[i]);
                        nxt_ref[i] = ref_ff[i] ^ cc_evt[i];
                    end
                    `CTU_CH_PWM1: begin
                        // Compare of zero gives 0 %, above reload gives 100 %
                        nxt_ref[i] = (cnt_ff < ccr_ff[i]);
                        cc_evt[i] = cnt_tick && (cnt_ff == ccr_ff[i]);
                    end
                    `CTU_CH_PWM2: begin
                        nxt_ref[i] = ~(cnt_ff < ccr_ff[i]);
                        cc_evt[i] = cnt_tick && (cnt_ff == ccr_ff[i]);
                    end
                    default: begin
                        nxt_ref[i] = 1'b0;
                    end
                endcase
            end else begin
                nxt_ref[i] = 1'b0;
            end
        end
    end

    // Sticky status: hardware set wins over the write-one clear
    always @* begin
        nxt_stat = stat_ff;
        if (wr_stat) begin
            nxt_stat = stat_ff & ~wdata_in[`CTU_ST_W-1:0];
        end
        nxt_stat[`CTU_ST_UPD] = nxt_stat[`CTU_ST_UPD] | upd;
        nxt_stat[`CTU_ST_CC0 +: 4] = nxt_stat[`CTU_ST_CC0 +: 4] | cc_evt;
        nxt_stat[`CTU_ST_TRG] = nxt_stat[`CTU_ST_TRG] | (trig_rise && (smcr_ff != `CTU_SM_OFF));
    end

    // Control with hardware start on trigger and stop after one pulse
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl = wdata_in[7:0];
            nxt_ctrl[`CTU_CTRL_DIRSTAT] = 1'b0;
        end
        if ((smcr_ff == `CTU_SM_START) && trig_rise) begin
            nxt_ctrl[`CTU_CTRL_EN] = 1'b1;
        end
        if (upd && ctrl_ff[`CTU_CTRL_OPM]) begin
            nxt_ctrl[`CTU_CTRL_EN] = 1'b0;
        end
    end

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_ff <= `CTU_RST_CTRL;
            psc_ff <= `CTU_RST_PSC;
            arr_ff <= `CTU_RST_ARR;
            cnt_ff <= 32'h0;
            dir_ff <= 1'b0;
            ccmr_ff <= 16'h0000;
            for (j = 0; j < 4; j = j + 1) begin
                ccr_ff[j] <= 32'h0;
            end
            dtr_ff <= `CTU_RST_DTR;
            smcr_ff <= `CTU_SM_OFF;
            stat_ff <= {`CTU_ST_W{1'b0}};
            ier_ff <= {`CTU_ST_W{1'b0}};
            dmaen_ff <= {`CTU_ST_W{1'b0}};
            chin_d_ff <= 4'h0;
            trig_d_ff <= 1'b0;
            ref_ff <= 4'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
            stat_ff <= nxt_stat;
            ref_ff <= nxt_ref;
            chin_d_ff <= ch_in;
            trig_d_ff <= trig_in;
            for (j = 0; j < 4; j = j + 1) begin
                if (cc_evt[j] && (ccmr_ff[4*j +: 3] == `CTU_CH_CAP)) begin
                    ccr_ff[j] <= cnt_ff;
                end else if (wr_in && (addr_in == `CTU_OFF_CCR0 + 8'h04 * j[7:0])) begin
                    ccr_ff[j] <= wdata_in & CMASK;
                end
            end
            if (wr_in) begin
                case (addr_in)
                    `CTU_OFF_PSC: psc_ff <= wdata_in[15:0];
                    `CTU_OFF_ARR: arr_ff <= wdata_in & CMASK;
                    `CTU_OFF_CCMR: ccmr_ff <= wdata_in[15:0];
                    `CTU_OFF_DTR: dtr_ff <= wdata_in[9:0];
                    `CTU_OFF_SMCR: smcr_ff <= wdata_in[2:0];
                    `CTU_OFF_IER: ier_ff <= wdata_in[`CTU_ST_W-1:0];
                    `CTU_OFF_DMAEN: dmaen_ff <= wdata_in[`CTU_ST_W-1:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read mux
    always @* begin
        rd_val = 32'h0;
        case (addr_in)
            `CTU_OFF_CTRL: rd_val = {24'h0, dir_ff, ctrl_ff[6:0]};
            `CTU_OFF_PSC: rd_val = {16'h0, psc_ff};
            `CTU_OFF_ARR: rd_val = arr_ff;
            `CTU_OFF_CNT: rd_val = cnt_ff;
            `CTU_OFF_CCMR: rd_val = {16'h0, ccmr_ff};
            `CTU_OFF_CCR0: rd_val = ccr_ff[0];
            `CTU_OFF_CCR1: rd_val = ccr_ff[1];
            `CTU_OFF_CCR2: rd_val = ccr_ff[2];
            `CTU_OFF_CCR3: rd_val = ccr_ff[3];
            `CTU_OFF_DTR: rd_val = {22'h0, dtr_ff};
            `CTU_OFF_SMCR: rd_val = {29'h0, smcr_ff};
            `CTU_OFF_STAT: rd_val = {26'h0, stat_ff};
            `CTU_OFF_IER: rd_val = {26'h0, ier_ff};
            `CTU_OFF_DMAEN: rd_val = {26'h0, dmaen_ff};
            default: rd_val = 32'h0;
        endcase
    end

    // Registered outputs
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 32'h0;
            trgo_out <= 1'b0;
            dac_trig_out <= 1'b0;
            irq_out <= 1'b0;
            dma_req_out <= 1'b0;
            kernel_clock_double_select_out <= 1'b0;
        end else begin
            rdata_out <= rd_in ? rd_val : 32'h0;
            trgo_out <= upd;
            dac_trig_out <= upd && (VARIANT == `CTU_VAR_BASIC);
            irq_out <= |(nxt_stat & ier_ff);
            dma_req_out <= HAS_DMA && (|(nxt_stat & dmaen_ff));
            kernel_clock_double_select_out <= nxt_ctrl[`CTU_CTRL_KDS];
        end
    end

    // Output stages: complementary pairs with dead time on the first three
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_out
            wire moe_ok = !IS_ADV || dtr_ff[`CTU_DTR_MOE];
            wire comp_ok = IS_ADV && (g < 3) && dtr_ff[`CTU_DTR_CPE] && dtr_ff[`CTU_DTR_MOE];
            ctu_deadtime u_dt (
                .clk_in(clk_in),
                .resetn_in(resetn_in),
                .ref_in(ref_ff[g] & moe_ok),
                .comp_en_in(comp_ok),
                .dead_in(dtr_ff[`CTU_DTR_DT_HI:0]),
                .p_out(ch_out[g]),
                .n_out(chn_out[g])
            );
        end
    endgenerate
endmodule // ctu_timer
`default_nettype wire

// *** ctu_timer_unused_placeholder_never.v ***
// Intentionally empty
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** ctu_timer_properties.sv ***
// Port assertions for the timer unit
`timescale 1ns/100ps
`default_nettype none
`include "ctu_regs.vh"
module ctu_timer_chk #(
    parameter [1:0] VARIANT = `CTU_VAR_ADV
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic dbg_halt_in,
    input wire logic [31:0] rdata_out,
    input wire logic [3:0] ch_out,
    input wire logic [3:0] chn_out,
    input wire logic trgo_out,
    input wire logic dac_trig_out,
    input wire logic irq_out,
    input wire logic dma_req_out,
    input wire logic kernel_clock_double_select_out
);
    reg [5:0] ier_ff;
    reg [5:0] dma_ff;
    reg frz_ff;
    reg moe_ff;
    // Shadow copies of the mask and control bits written over the bus
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ier_ff <= 6'h00;
            dma_ff <= 6'h00;
            frz_ff <= 1'b0;
            moe_ff <= 1'b0;
        end else if (wr_in) begin
            if (addr_in == `CTU_OFF_IER) ier_ff <= wdata_in[5:0];
            if (addr_in == `CTU_OFF_DMAEN) dma_ff <= wdata_in[5:0];
            if (addr_in == `CTU_OFF_CTRL) frz_ff <= wdata_in[`CTU_CTRL_FRZ];
            if (addr_in == `CTU_OFF_DTR) moe_ff <= wdata_in[`CTU_DTR_MOE];
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_ctrl_wr;
        wr_in && addr_in == `CTU_OFF_CTRL;
    endsequence
    sequence s_ctrl_settle;
        s_ctrl_wr ##1 !(wr_in && addr_in == `CTU_OFF_CTRL);
    endsequence
    a_rdata_idle_zero: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not zero outside read answer");
    a_unmapped_reads_zero: assert property (rd_in && addr_in == 8'hfc |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_irq_stays_set: assert property (irq_out && !wr_in && !$past(wr_in) |=> irq_out)
        else $error("interrupt dropped without a write");
    a_irq_mask_off: assert property (ier_ff == 6'h00 |=> !irq_out)
        else $error("interrupt with all sources masked");
    a_dma_mask_off: assert property (dma_ff == 6'h00 |=> !dma_req_out)
        else $error("dma request with all sources masked");
    a_kds_mirror_bit: assert property (s_ctrl_settle |=> kernel_clock_double_select_out == $past(wdata_in[6], 2))
        else $error("kernel clock select does not follow control bit");
    a_dac_trig_quiet: assert property (VARIANT != `CTU_VAR_BASIC |-> !dac_trig_out)
        else $error("dac trigger on a non-basic variant");
    a_freeze_no_update: assert property (frz_ff && dbg_halt_in |=> !trgo_out)
        else $error("update while frozen in debug");
    a_spare_pair_low: assert property (chn_out[3] == 1'b0)
        else $error("fourth complementary output driven");
    a_moe_gates_out: assert property ((VARIANT == `CTU_VAR_ADV && !moe_ff) [*4] |->
        ch_out == 4'h0 && chn_out == 4'h0)
        else $error("outputs active with main enable off");
endmodule // ctu_timer_chk
bind ctu_timer ctu_timer_chk #(.VARIANT(VARIANT)) chk_u (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .dbg_halt_in(dbg_halt_in), .rdata_out(rdata_out),
    .ch_out(ch_out), .chn_out(chn_out), .trgo_out(trgo_out), .dac_trig_out(dac_trig_out),
    .irq_out(irq_out), .dma_req_out(dma_req_out),
    .kernel_clock_double_select_out(kernel_clock_double_select_out)
);
`default_nettype wire

// *** ctu_drive_model.sv ***
// Power stage load and capture sensor facing the timer channels
`timescale 1ns/100ps
`default_nettype none
module ctu_drive_model (
    input wire logic clk_in,
    input wire logic [3:0] hi_in,
    input wire logic [3:0] lo_in,
    input wire logic edge_req_in,
    output logic [3:0] sense_out,
    output logic short_out
);
    logic [2:0] hold_ff = 3'h0;
    logic short_ff = 1'b0;
    // Sensor pulse on channel 1, flag if a bridge leg sees both switches on
    always @(posedge clk_in) begin
        if (edge_req_in) hold_ff <= 3'h4;
        else if (hold_ff != 3'h0) hold_ff <= hold_ff - 3'h1;
        if (|(hi_in & lo_in)) short_ff <= 1'b1;
    end
    assign short_out = short_ff;
    assign sense_out = {2'b00, hold_ff != 3'h0, 1'b0};
endmodule // ctu_drive_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the timer unit
`timescale 1ns/100ps
`default_nettype none
`include "ctu_regs.vh"
module tb_top;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic trig_in = 1'b0;
    logic dbg_halt_in = 1'b0;
    logic edge_req = 1'b0;
    wire [3:0] ch_in;
    wire [3:0] ch_out;
    wire [3:0] chn_out;
    wire [31:0] rdata_out;
    wire trgo_out, dac_trig_out, irq_out, dma_req_out, kds_out, short_seen;
    integer error_cnt = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer k;
    logic [31:0] v, w, c;
    always #2.5 clk_in = ~clk_in;
    ctu_timer #(.VARIANT(`CTU_VAR_ADV), .WIDE(0)) dut_u (
        .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .ch_in(ch_in), .trig_in(trig_in),
        .dbg_halt_in(dbg_halt_in), .rdata_out(rdata_out), .ch_out(ch_out),
        .chn_out(chn_out), .trgo_out(trgo_out), .dac_trig_out(dac_trig_out),
        .irq_out(irq_out), .dma_req_out(dma_req_out),
        .kernel_clock_double_select_out(kds_out));
    ctu_drive_model drv_u (.clk_in(clk_in), .hi_in(ch_out), .lo_in(chn_out),
        .edge_req_in(edge_req), .sense_out(ch_in), .short_out(short_seen));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("FAIL t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask
    task automatic period(output integer p);
        integer i;
        for (i = 0; i < 200 && trgo_out !== 1'b1; i++) @(negedge clk_in);
        p = 1;
        @(negedge clk_in);
        while (trgo_out !== 1'b1 && p < 200) begin
            p++;
            @(negedge clk_in);
        end
    endtask
    task automatic t_regs;
        rd(`CTU_OFF_ARR, v);
        chk(v, `CTU_RST_ARR);
        rd(8'hfc, v);
        chk(v, 32'h0);
        wr(`CTU_OFF_ARR, 32'h12345678);
        rd(`CTU_OFF_ARR, v);
        chk(v, 32'h00005678);
        wr(`CTU_OFF_PSC, 32'h00012345);
        rd(`CTU_OFF_PSC, v);
        chk(v, 32'h00002345);
    endtask
    task automatic t_update;
        wr(`CTU_OFF_PSC, 32'h1);
        wr(`CTU_OFF_ARR, 32'h2);
        wr(`CTU_OFF_IER, 32'h1);
        wr(`CTU_OFF_DMAEN, 32'h1);
        wr(`CTU_OFF_CTRL, 32'h1);
        period(k);
        chk(k, 6);
        chk({31'h0, irq_out}, 32'h1);
        chk({31'h0, dma_req_out}, 32'h1);
        wr(`CTU_OFF_IER, 32'h0);
        repeat (3) @(negedge clk_in);
        chk({31'h0, irq_out}, 32'h0);
        wr(`CTU_OFF_CTRL, 32'h0);
        wr(`CTU_OFF_STAT, 32'h3f);
        rd(`CTU_OFF_STAT, v);
        chk(v, 32'h0);
        chk({31'h0, dma_req_out}, 32'h0);
    endtask
    task automatic t_down_freeze;
        wr(`CTU_OFF_PSC, 32'h0);
        wr(`CTU_OFF_ARR, 32'h4);
        wr(`CTU_OFF_CTRL, 32'h3);
        period(k);
        chk(k, 5);
        rd(`CTU_OFF_CTRL, v);
        chk(v & 32'h80, 32'h80);
        wr(`CTU_OFF_CTRL, 32'h21);
        dbg_halt_in <= 1'b1;
        rd(`CTU_OFF_CNT, v);
        rd(`CTU_OFF_CNT, w);
        chk(w, v);
        @(posedge clk_in);
        dbg_halt_in <= 1'b0;
        rd(`CTU_OFF_CNT, v);
        rd(`CTU_OFF_CNT, w);
        chk({31'h0, w !== v}, 32'h1);
        wr(`CTU_OFF_CTRL, 32'h40);
        repeat (2) @(negedge clk_in);
        chk({31'h0, kds_out}, 32'h1);
        wr(`CTU_OFF_CTRL, 32'h11);
        repeat (20) @(negedge clk_in);
        chk({31'h0, kds_out}, 32'h0);
        rd(`CTU_OFF_CTRL, v);
        chk(v & 32'h1, 32'h0);
    endtask
    task automatic t_pwm;
        integer i;
        integer j;
        wr(`CTU_OFF_DTR, 32'h200);
        wr(`CTU_OFF_CCMR, 32'h3);
        wr(`CTU_OFF_ARR, 32'h3);
        for (i = 0; i < 4; i++) begin
            wr(`CTU_OFF_CCR0, (i == 3) ? 32'h4 : (i == 2) ? 32'h0 : 32'h1);
            wr(`CTU_OFF_CTRL, (i == 1) ? 32'h5 : 32'h1);
            repeat (20) @(negedge clk_in);
            k = 0;
            for (j = 0; j < 24; j++) begin
                @(negedge clk_in);
                if (ch_out[0] === 1'b1) k++;
            end
            chk(k, (i == 0) ? 6 : (i == 1) ? 4 : (i == 2) ? 0 : 24);
        end
    endtask
    task automatic t_dead;
        integer i;
        wr(`CTU_OFF_ARR, 32'hf);
        wr(`CTU_OFF_CCR0, 32'h8);
        wr(`CTU_OFF_DTR, 32'h303);
        for (i = 0; i < 100 && ch_out[0] !== 1'b1; i++) @(negedge clk_in);
        for (i = 0; i < 100 && ch_out[0] !== 1'b0; i++) @(negedge clk_in);
        k = 0;
        for (i = 0; i < 100 && chn_out[0] !== 1'b1; i++) begin
            k++;
            @(negedge clk_in);
        end
        chk(k, 3);
        chk({31'h0, short_seen}, 32'h0);
    endtask
    task automatic t_capture_link;
        wr(`CTU_OFF_ARR, 32'hffff);
        wr(`CTU_OFF_CCMR, 32'h10);
        rd(`CTU_OFF_CNT, v);
        edge_req <= 1'b1;
        @(posedge clk_in);
        edge_req <= 1'b0;
        repeat (10) @(posedge clk_in);
        rd(`CTU_OFF_CNT, w);
        rd(`CTU_OFF_CCR1, c);
        chk({31'h0, c >= v && c <= w}, 32'h1);
        rd(`CTU_OFF_STAT, v);
        chk(v & 32'h4, 32'h4);
        wr(`CTU_OFF_CTRL, 32'h0);
        wr(`CTU_OFF_SMCR, 32'h3);
        wr(`CTU_OFF_CNT, 32'h0);
        wr(`CTU_OFF_CTRL, 32'h1);
        repeat (5) begin
            trig_in <= 1'b1;
            repeat (2) @(posedge clk_in);
            trig_in <= 1'b0;
            repeat (2) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
        rd(`CTU_OFF_CNT, v);
        chk(v, 32'h5);
        rd(`CTU_OFF_STAT, v);
        chk(v & 32'h20, 32'h20);
        wr(`CTU_OFF_CTRL, 32'h0);
        wr(`CTU_OFF_SMCR, 32'h1);
        @(posedge clk_in);
        trig_in <= 1'b1;
        @(posedge clk_in);
        trig_in <= 1'b0;
        rd(`CTU_OFF_CTRL, v);
        chk(v & 32'h1, 32'h1);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            conclude;
        end
    end
    initial begin
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        t_regs;
        t_update;
        t_down_freeze;
        t_pwm;
        t_dead;
        t_capture_link;
        conclude;
    end
endmodule // tb_top
`default_nettype wire
